// ### common/cp_pkg.sv
// cp_pkg: constants and types of the code protection checker
// assumes one core clock; every address is a byte address
package cp_pkg;

  // address space of a table request
  localparam logic SPACE_PROG = 1'b0;
  localparam logic SPACE_DATA = 1'b1;

  // protection byte addresses in configuration space
  localparam logic [21:0] ADDR_REGION_READ_LOCK = 22'h300008;
  localparam logic [21:0] ADDR_BOOT_DATA_LOCK = 22'h300009;
  localparam logic [21:0] ADDR_REGION_WRITE_GUARD = 22'h30000a;
  localparam logic [21:0] ADDR_BOOT_DATA_CFG_GUARD = 22'h30000b;
  localparam logic [21:0] ADDR_REGION_TREAD_GUARD = 22'h30000c;
  localparam logic [21:0] ADDR_BOOT_TREAD_GUARD = 22'h30000d;
  localparam int PROT_REGS = 6;

  // index of each protection byte, counted from the first address
  localparam logic [2:0] IDX_RLOCK = 3'h0;
  localparam logic [2:0] IDX_BLOCK = 3'h1;
  localparam logic [2:0] IDX_RWG = 3'h2;
  localparam logic [2:0] IDX_BWG = 3'h3;
  localparam logic [2:0] IDX_RRG = 3'h4;
  localparam logic [2:0] IDX_BRG = 3'h5;

  // field positions
  localparam int BIT_DATA_LOCK = 7;
  localparam int BIT_BOOT_LOCK = 6;
  localparam int BIT_DATA_WG = 7;
  localparam int BIT_BOOT_WG = 6;
  localparam int BIT_CFG_WG = 5;
  localparam int BIT_BOOT_RG = 6;

  // implemented bits of each byte; also the erased (reset) value
  localparam logic [5:0][7:0] PROT_RESET =
    {8'h40, 8'h0f, 8'he0, 8'h0f, 8'hc0, 8'h0f};

  // user identification words
  localparam logic [21:0] ADDR_ID_FIRST = 22'h200000;
  localparam logic [21:0] ADDR_ID_LAST = 22'h200007;

  // region end addresses, indexed by variant: 8K, 16K, 32K, 64K
  localparam logic [3:0][16:0] BOOT_END =
    {17'h00800, 17'h00800, 17'h00800, 17'h00200};
  localparam logic [3:0][16:0] BLK0_END =
    {17'h04000, 17'h02000, 17'h02000, 17'h01000};
  localparam logic [3:0][16:0] BLK1_END =
    {17'h08000, 17'h04000, 17'h04000, 17'h02000};
  localparam logic [3:0][16:0] BLK2_END =
    {17'h0c000, 17'h06000, 17'h04000, 17'h02000};
  localparam logic [3:0][16:0] PROG_TOP =
    {17'h10000, 17'h08000, 17'h04000, 17'h02000};

  // resources held back while the debugger is enabled
  localparam logic [16:0] DBG_PMEM_BYTES = 17'd512;
  localparam int DBG_STACK_LEVELS = 2;
  localparam int DBG_DMEM_BYTES = 10;

  typedef enum logic [2:0] {
    RG_BOOT = 3'b000,
    RG_BLK0 = 3'b001,
    RG_BLK1 = 3'b010,
    RG_BLK2 = 3'b011,
    RG_BLK3 = 3'b100,
    RG_NONE = 3'b111
  } region_t;

  typedef struct packed {
    logic wr;
    logic space;
    logic [21:0] addr;
    logic [7:0] wdata;
  } req_t;

endpackage

// ### logic/region_decoder.sv
// region_decoder: maps a program address to its protection region
// assumes variant is stable while addresses are presented
`timescale 1ns/100ps
`default_nettype none
module region_decoder import cp_pkg::*; (
  // map selection
  input wire logic [1:0] variant,
  // address to classify
  input wire logic [20:0] addr,
  // result
  output region_t region,
  output logic impl
);

  logic [20:0] b_end;
  logic [20:0] k0_end;
  logic [20:0] k1_end;
  logic [20:0] k2_end;
  logic [20:0] top;

  // boundaries of the selected variant
  assign b_end = 21'(BOOT_END[variant]);
  assign k0_end = 21'(BLK0_END[variant]);
  assign k1_end = 21'(BLK1_END[variant]);
  assign k2_end = 21'(BLK2_END[variant]);
  assign top = 21'(PROG_TOP[variant]);

  // beyond the top is unimplemented space
  assign impl = addr < top;
  assign region = !impl ? RG_NONE :
                  (addr < b_end) ? RG_BOOT :
                  (addr < k0_end) ? RG_BLK0 :
                  (addr < k1_end) ? RG_BLK1 :
                  (addr < k2_end) ? RG_BLK2 : RG_BLK3;

endmodule
`default_nettype wire

// ### logic/code_protection_checker.sv
// code_protection_checker: guards table access to program flash,
// data nonvolatile memory, protection bytes and id words
// assumes request and strap inputs come from logic on ref_clk
`timescale 1ns/100ps
`default_nettype none
module code_protection_checker import cp_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // device configuration
  input wire logic [1:0] variant,
  input wire logic debug_cfg_n,
  input wire logic prog_mode,
  // cpu table port
  input wire logic cpu_valid,
  input wire req_t cpu_req,
  input wire logic [20:0] cpu_pc,
  // programming link port
  input wire logic ext_valid,
  input wire req_t ext_req,
  input wire logic ext_chip_erase,
  input wire logic ext_blk_erase,
  input wire region_t ext_blk_sel,
  // memory array side
  output logic mem_rd_r,
  output logic mem_wr_r,
  output logic mem_space_r,
  output logic [21:0] mem_addr_r,
  output logic [7:0] mem_wdata_r,
  input wire logic [7:0] mem_rdata,
  // answer to the active port
  output logic resp_valid_r,
  output logic resp_refused_r,
  output logic [7:0] resp_rdata_r,
  // debug status
  output logic debug_en_r
);

  logic take_cpu;
  logic take_ext;
  logic take;
  logic from_ext;
  req_t rq;
  logic is_prog;
  logic is_data;
  logic is_id;
  logic is_cfg;
  logic [2:0] cfg_idx;
  region_t tgt_region;
  region_t pc_region;
  logic tgt_impl;
  logic pc_impl;
  logic [4:0] lock_v;
  logic [4:0] wg_v;
  logic [4:0] rg_v;
  logic [4:0] inert;
  logic [4:0] lock_e;
  logic [4:0] wg_e;
  logic [4:0] rg_e;
  logic data_lock;
  logic data_wg;
  logic cfg_wg;
  logic dbg_zone;
  logic prog_rd_ok;
  logic prog_wr_ok;
  logic rd_ok;
  logic wr_ok;
  logic ok;
  logic pass;
  logic cfg_wr;
  logic [7:0] keep_mask;
  logic [7:0] wd_eff;
  logic erase_chip;
  logic erase_blk;
  logic erase_any;
  logic [7:0] blk_mask;
  logic [7:0] boot_mask;
  logic [7:0] cfg_rd;
  logic [7:0] prot_r [PROT_REGS];
  logic [7:0] prot_nxt [PROT_REGS];
  logic [8*PROT_REGS-1:0] prot_flat;
  logic s1_v_r;
  logic s1_ref_r;
  logic [7:0] s1_cfg_r;

  // one port at a time: the link while programming, else the cpu
  assign take_ext = ext_valid & prog_mode;
  assign take_cpu = cpu_valid & ~prog_mode;
  assign take = take_ext | take_cpu;
  assign from_ext = prog_mode;
  assign rq = prog_mode ? ext_req : cpu_req;

  // target classification of the request
  assign is_data = rq.space == SPACE_DATA;
  assign is_prog = ~is_data & (rq.addr < ADDR_ID_FIRST);
  assign is_id = ~is_data & (rq.addr >= ADDR_ID_FIRST) &
                 (rq.addr <= ADDR_ID_LAST);
  assign is_cfg = ~is_data & (rq.addr >= ADDR_REGION_READ_LOCK) &
                  (rq.addr <= ADDR_BOOT_TREAD_GUARD);
  assign cfg_idx = 3'(rq.addr - ADDR_REGION_READ_LOCK);

  // region of the target and of the executing instruction
  region_decoder u_tgt_dec (
    .variant(variant),
    .addr(rq.addr[20:0]),
    .region(tgt_region),
    .impl(tgt_impl)
  );

  region_decoder u_pc_dec (
    .variant(variant),
    .addr(cpu_pc),
    .region(pc_region),
    .impl(pc_impl)
  );

  // per-region controls, boot at index 0, blocks 0..3 above
  assign lock_v = {prot_r[IDX_RLOCK][3:0],
                   prot_r[IDX_BLOCK][BIT_BOOT_LOCK]};
  assign wg_v = {prot_r[IDX_RWG][3:0],
                 prot_r[IDX_BWG][BIT_BOOT_WG]};
  assign rg_v = {prot_r[IDX_RRG][3:0],
                 prot_r[IDX_BRG][BIT_BOOT_RG]};

  // blocks 2 and 3 keep their bits but never restrict small parts
  assign inert = variant[1] ? 5'h00 : 5'h18;
  assign lock_e = lock_v | inert;
  assign wg_e = wg_v | inert;
  assign rg_e = rg_v | inert;

  // data memory and configuration bits
  assign data_lock = prot_r[IDX_BLOCK][BIT_DATA_LOCK];
  assign data_wg = prot_r[IDX_BWG][BIT_DATA_WG];
  assign cfg_wg = prot_r[IDX_BWG][BIT_CFG_WG];

  // debugger claims the top of program memory while enabled
  assign dbg_zone = debug_en_r &
    (rq.addr >= 22'(PROG_TOP[variant] - DBG_PMEM_BYTES));

  // program memory: cpu obeys guards, link obeys the external lock
  assign prog_rd_ok = from_ext ? lock_e[tgt_region]
    : (rg_e[tgt_region] | (pc_impl & (pc_region == tgt_region)));
  assign prog_wr_ok = from_ext ? lock_e[tgt_region]
    : (wg_e[tgt_region] & ~dbg_zone);

  // verdict per target class
  assign rd_ok = is_data ? (~from_ext | data_lock) :
                 is_prog ? (~tgt_impl | prog_rd_ok) : 1'b1;
  assign wr_ok = is_data ? (data_wg & (~from_ext | data_lock)) :
                 is_prog ? (tgt_impl & prog_wr_ok) :
                 is_id ? 1'b1 :
                 is_cfg ? (from_ext | cfg_wg) : 1'b0;
  assign ok = rq.wr ? wr_ok : rd_ok;
  assign pass = take & ok & (is_data | is_id | (is_prog & tgt_impl));

  // protection byte writes clear only; cpu cannot touch cfg guard
  assign cfg_wr = take & rq.wr & is_cfg & wr_ok;
  assign keep_mask = (~from_ext & (cfg_idx == IDX_BWG)) ?
                     8'(1 << BIT_CFG_WG) : 8'h00;
  assign wd_eff = rq.wdata | keep_mask;

  // erase is accepted only from the link in programming mode
  assign erase_chip = prog_mode & ext_chip_erase;
  assign erase_blk = prog_mode & ext_blk_erase;
  assign erase_any = erase_chip | erase_blk;
  assign blk_mask = (ext_blk_sel == RG_BOOT) ? 8'h00 :
                    8'(8'h01 << (ext_blk_sel - 3'd1));
  assign boot_mask = (ext_blk_sel == RG_BOOT) ?
                     8'(1 << BIT_BOOT_LOCK) : 8'h00;

  // next value of each protection byte; erase wins over a write
  for (genvar g = 0; g < PROT_REGS; g++) begin : g_prot
    logic [7:0] set_m;
    logic [7:0] kept;
    assign set_m = erase_chip ? 8'hff :
                   !erase_blk ? 8'h00 :
                   (g % 2 == 1) ? boot_mask : blk_mask;
    assign kept = (cfg_wr & (cfg_idx == 3'(g))) ?
                  (prot_r[g] & wd_eff) : prot_r[g];
    assign prot_nxt[g] = PROT_RESET[g] & (kept | set_m);
    assign prot_flat[g*8 +: 8] = prot_r[g];
  end

  // read view of a protection byte; unimplemented bits read zero
  assign cfg_rd = (take & is_cfg & ~rq.wr) ? prot_r[cfg_idx] : 8'h00;

  // protection storage, erased state after reset
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < PROT_REGS; i++) begin
      prot_r[i] <= sys_rst ? PROT_RESET[i] : prot_nxt[i];
    end
  end

  // debug enable follows the configuration bit
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      debug_en_r <= 1'b0;
    end else begin
      debug_en_r <= ~debug_cfg_n;
    end
  end

  // stage one: present the checked access to the memory array
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_space_r <= 1'b0;
      mem_addr_r <= 22'h000000;
      mem_wdata_r <= 8'h00;
      s1_v_r <= 1'b0;
      s1_ref_r <= 1'b0;
      s1_cfg_r <= 8'h00;
    end else begin
      mem_rd_r <= pass & ~rq.wr;
      mem_wr_r <= pass & rq.wr;
      mem_space_r <= rq.space;
      mem_addr_r <= rq.addr;
      mem_wdata_r <= rq.wdata;
      s1_v_r <= take;
      s1_ref_r <= take & ~ok;
      s1_cfg_r <= cfg_rd;
    end
  end

  // stage two: answer; refused and unimplemented reads give zeros
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      resp_valid_r <= 1'b0;
      resp_refused_r <= 1'b0;
      resp_rdata_r <= 8'h00;
    end else begin
      resp_valid_r <= s1_v_r;
      resp_refused_r <= s1_ref_r;
      resp_rdata_r <= mem_rd_r ? mem_rdata : s1_cfg_r;
    end
  end

  // checks on the guarded paths
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_EXT_LOCK: assert property (
    take_ext & is_prog & tgt_impl & ~lock_e[tgt_region]
    |=> !mem_rd_r && !mem_wr_r ##1 resp_valid_r && resp_refused_r)
    else $error("link reached a locked region");

  AST_CPU_IGNORES_LOCK: assert property (
    take_cpu & ~rq.wr & is_prog & tgt_impl & rg_e[tgt_region]
    |=> mem_rd_r)
    else $error("cpu read blocked by external lock");

  AST_WRITE_GUARD: assert property (
    take_cpu & rq.wr & is_prog & tgt_impl & ~wg_e[tgt_region]
    |=> !mem_wr_r ##1 resp_refused_r)
    else $error("table write passed a write guard");

  AST_READ_GUARD: assert property (
    take_cpu & ~rq.wr & is_prog & tgt_impl & ~rg_e[tgt_region] &
    (pc_region != tgt_region)
    |-> ##2 resp_valid_r && resp_refused_r && resp_rdata_r == 8'h00)
    else $error("guarded read returned data");

  AST_CLEAR_ONLY: assert property (
    !erase_any |=> (prot_flat & ~$past(prot_flat)) == '0)
    else $error("protection bit set without erase");

  AST_SET_BY_ERASE: assert property (
    (prot_flat & ~$past(prot_flat)) != '0
    |-> $past(sys_rst) || ($past(erase_any) && $past(prog_mode)))
    else $error("protection bit set outside link erase");

  AST_DATA_LOCK: assert property (
    take_ext & is_data & ~data_lock |=> !mem_rd_r && !mem_wr_r)
    else $error("link reached locked data memory");

  AST_DATA_WG: assert property (
    take & is_data & rq.wr & ~data_wg |=> !mem_wr_r ##1 resp_refused_r)
    else $error("data write passed its guard");

  AST_DATA_CPU_READ: assert property (
    take_cpu & is_data & ~rq.wr |=> mem_rd_r ##1 !resp_refused_r)
    else $error("cpu data read refused");

  AST_CFG_GUARD: assert property (
    take_cpu & rq.wr & is_cfg
    |=> $stable(prot_flat[8*IDX_BWG + BIT_CFG_WG]))
    else $error("cpu changed the config write guard");

  AST_ID_READ: assert property (
    take & is_id & ~rq.wr |=> mem_rd_r ##1 !resp_refused_r)
    else $error("id word read refused");

  AST_UNIMPL_ZERO: assert property (
    take & is_prog & ~tgt_impl & ~rq.wr
    |=> !mem_rd_r ##1 resp_rdata_r == 8'h00 && !resp_refused_r)
    else $error("unimplemented read not zero");

  AST_SMALL_INERT: assert property (
    take & is_prog & ~variant[1]
    |-> tgt_region != RG_BLK2 && tgt_region != RG_BLK3)
    else $error("small part decoded block 2 or 3");

  AST_DEBUG_ZONE: assert property (
    take_cpu & rq.wr & is_prog & tgt_impl & dbg_zone |=> !mem_wr_r)
    else $error("write into debugger memory");

  // main scenarios
  COV_READ_HIDDEN: cover property (
    take_cpu & ~rq.wr & is_prog & ~ok ##2 resp_refused_r);
  COV_CHIP_ERASE: cover property (erase_chip ##1 prot_flat != '0);
  COV_LOCK_CLEAR: cover property (cfg_wr ##1 (prot_flat != $past(prot_flat)));
  COV_DEBUG_BLOCK: cover property (take_cpu & rq.wr & dbg_zone);
  COV_BOOT_ERASE: cover property (erase_blk & (ext_blk_sel == RG_BOOT));

endmodule
`default_nettype wire

// ### dv/prog_link_model.sv
// prog_link_model: external programmer driving the link request port
// assumes the bench calls its tasks just after a rising edge of ref_clk
`timescale 1ns/100ps
`default_nettype none
module prog_link_model import cp_pkg::*; (
  // clock
  input wire logic ref_clk,
  // link request side
  output logic ext_valid,
  output req_t ext_req,
  output logic ext_chip_erase,
  output logic ext_blk_erase,
  output region_t ext_blk_sel
);
  // idle link: no request, no erase
  initial begin
    ext_valid = 1'b0;
    ext_req = '0;
    ext_chip_erase = 1'b0;
    ext_blk_erase = 1'b0;
    ext_blk_sel = RG_NONE;
  end

  // one serial frame condensed to one request, qualifiers scrambled after
  task automatic send(input req_t r);
    @(posedge ref_clk);
    #1;
    ext_valid = 1'b1;
    ext_req = r;
    @(posedge ref_clk);
    #1;
    ext_valid = 1'b0;
    ext_req = ~r;
  endtask

  // chip or block erase, only this side can ask for it
  task automatic erase(input logic chip, input region_t sel);
    @(posedge ref_clk);
    #1;
    ext_chip_erase = chip;
    ext_blk_erase = !chip;
    ext_blk_sel = sel;
    @(posedge ref_clk);
    #1;
    ext_chip_erase = 1'b0;
    ext_blk_erase = 1'b0;
    ext_blk_sel = RG_NONE;
  endtask
endmodule
`default_nettype wire

// ### dv/test_code_protection_checker.sv
// test_code_protection_checker: table access sequences with expectations
// assumes a combinational memory array answering addr xor 5ah
`timescale 1ns/100ps
`default_nettype none
module test_code_protection_checker import cp_pkg::*;;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [1:0] variant = 2'h0;
  logic debug_cfg_n = 1'b1;
  logic prog_mode = 1'b0;
  logic cpu_valid = 1'b0;
  req_t cpu_req = '0;
  logic [20:0] cpu_pc = '0;
  wire logic ext_valid;
  req_t ext_req;
  wire logic ext_chip_erase;
  wire logic ext_blk_erase;
  region_t ext_blk_sel;
  wire logic mem_rd_r;
  wire logic mem_wr_r;
  wire logic mem_space_r;
  wire logic [21:0] mem_addr_r;
  wire logic [7:0] mem_wdata_r;
  wire logic [7:0] mem_rdata;
  wire logic resp_valid_r;
  wire logic resp_refused_r;
  wire logic [7:0] resp_rdata_r;
  wire logic debug_en_r;
  int fail_count = 0;
  int checks = 0;

  // clock and memory array model
  always #10 ref_clk = ~ref_clk;
  assign mem_rdata = mem_addr_r[7:0] ^ 8'h5a;

  code_protection_checker u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .variant(variant), .debug_cfg_n(debug_cfg_n), .prog_mode(prog_mode),
    .cpu_valid(cpu_valid), .cpu_req(cpu_req), .cpu_pc(cpu_pc),
    .ext_valid(ext_valid), .ext_req(ext_req),
    .ext_chip_erase(ext_chip_erase), .ext_blk_erase(ext_blk_erase),
    .ext_blk_sel(ext_blk_sel), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
    .mem_space_r(mem_space_r), .mem_addr_r(mem_addr_r),
    .mem_wdata_r(mem_wdata_r), .mem_rdata(mem_rdata),
    .resp_valid_r(resp_valid_r), .resp_refused_r(resp_refused_r),
    .resp_rdata_r(resp_rdata_r), .debug_en_r(debug_en_r));

  prog_link_model u_link (.ref_clk(ref_clk), .ext_valid(ext_valid),
    .ext_req(ext_req), .ext_chip_erase(ext_chip_erase),
    .ext_blk_erase(ext_blk_erase), .ext_blk_sel(ext_blk_sel));

  // expected array data for an address
  function automatic logic [7:0] md(input logic [21:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction

  // compare and count
  task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  // one table request on cpu or link port, answer two cycles on
  task automatic acc(input logic lnk, input logic wr, input logic sp,
      input logic [21:0] a, input logic [7:0] wd, input logic [20:0] pc,
      input logic eref, input logic [7:0] erd);
    req_t r;
    r = '{wr: wr, space: sp, addr: a, wdata: wd};
    if (lnk) begin
      u_link.send(r);
    end else begin
      @(posedge ref_clk);
      #1;
      cpu_valid = 1'b1;
      cpu_req = r;
      cpu_pc = pc;
      @(posedge ref_clk);
      #1;
      cpu_valid = 1'b0;
      cpu_req = ~r;
      cpu_pc = ~pc;
    end
    if (eref) chk("mem strobe", 8'h00, {7'h00, mem_rd_r | mem_wr_r});
    // accepted writes outside config space reach the array
    if (!eref && wr && (sp || a[21:20] != 2'h3)) begin
      chk("mem write", 8'h01, {7'h00, mem_wr_r});
      chk("mem wdata", wd, mem_wdata_r);
      chk("mem space", {7'h00, sp}, {7'h00, mem_space_r});
      chk("mem addr lo", a[7:0], mem_addr_r[7:0]);
      chk("mem addr hi", a[21:14], mem_addr_r[21:14]);
    end
    @(posedge ref_clk);
    #1;
    chk("resp valid", 8'h01, {7'h00, resp_valid_r});
    chk("resp refused", {7'h00, eref}, {7'h00, resp_refused_r});
    chk("resp data", erd, resp_rdata_r);
  endtask

  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < PROT_REGS; i++) begin
      acc(0, 0, 0, 22'(ADDR_REGION_READ_LOCK + i), 8'h00, 21'h0, 0,
        PROT_RESET[i]);
    end
    $display("test reset values done");
    acc(0, 0, 0, 22'h000400, 8'h00, 21'h100, 0, md(22'h400));
    acc(0, 0, 1, 22'h000010, 8'h00, 21'h100, 0, md(22'h10));
    acc(0, 0, 0, 22'h002000, 8'h00, 21'h100, 0, 8'h00);
    acc(0, 1, 0, 22'h200007, 8'ha5, 21'h100, 0, 8'h00);
    acc(0, 0, 0, 22'h200000, 8'h00, 21'h100, 0, md(22'h0));
    $display("test plain access done");
    acc(0, 1, 0, ADDR_BOOT_TREAD_GUARD, 8'h00, 21'h0, 0, 8'h00);
    acc(0, 0, 0, 22'h000100, 8'h00, 21'h300, 1, 8'h00);
    acc(0, 0, 0, 22'h000100, 8'h00, 21'h1ff, 0, md(22'h100));
    variant = 2'h1;
    acc(0, 0, 0, 22'h000100, 8'h00, 21'h300, 0, md(22'h100));
    variant = 2'h0;
    acc(0, 1, 0, ADDR_BOOT_TREAD_GUARD, 8'hff, 21'h0, 0, 8'h00);
    acc(0, 0, 0, ADDR_BOOT_TREAD_GUARD, 8'h00, 21'h0, 0, 8'h00);
    acc(0, 0, 0, 22'h200003, 8'h00, 21'h300, 0, md(22'h3));
    $display("test read guard done");
    acc(0, 1, 0, ADDR_REGION_WRITE_GUARD, 8'h02, 21'h0, 0, 8'h00);
    acc(0, 1, 0, 22'h000400, 8'h11, 21'h100, 1, 8'h00);
    acc(0, 1, 0, 22'h001000, 8'h22, 21'h100, 0, 8'h00);
    $display("test write guard done");
    acc(0, 1, 0, ADDR_REGION_READ_LOCK, 8'h0e, 21'h0, 0, 8'h00);
    acc(0, 0, 0, 22'h000400, 8'h00, 21'h400, 0, md(22'h400));
    prog_mode = 1'b1;
    acc(1, 0, 0, 22'h000400, 8'h00, 21'h0, 1, 8'h00);
    acc(1, 0, 0, 22'h001000, 8'h00, 21'h0, 0, md(22'h1000));
    $display("test external lock done");
    prog_mode = 1'b0;
    acc(0, 1, 0, ADDR_BOOT_DATA_LOCK, 8'h40, 21'h0, 0, 8'h00);
    acc(0, 1, 0, ADDR_BOOT_DATA_CFG_GUARD, 8'h60, 21'h0, 0, 8'h00);
    acc(0, 0, 1, 22'h000020, 8'h00, 21'h0, 0, md(22'h20));
    acc(0, 1, 1, 22'h000020, 8'h44, 21'h0, 1, 8'h00);
    prog_mode = 1'b1;
    acc(1, 0, 1, 22'h000020, 8'h00, 21'h0, 1, 8'h00);
    acc(1, 1, 1, 22'h000020, 8'h44, 21'h0, 1, 8'h00);
    $display("test data memory done");
    prog_mode = 1'b0;
    acc(0, 1, 0, ADDR_BOOT_DATA_CFG_GUARD, 8'h40, 21'h0, 0, 8'h00);
    acc(0, 0, 0, ADDR_BOOT_DATA_CFG_GUARD, 8'h00, 21'h0, 0, 8'h60);
    prog_mode = 1'b1;
    acc(1, 1, 0, ADDR_BOOT_DATA_CFG_GUARD, 8'h40, 21'h0, 0, 8'h00);
    prog_mode = 1'b0;
    acc(0, 0, 0, ADDR_BOOT_DATA_CFG_GUARD, 8'h00, 21'h0, 0, 8'h40);
    acc(0, 1, 0, ADDR_REGION_READ_LOCK, 8'h00, 21'h0, 1, 8'h00);
    $display("test config guard done");
    u_link.erase(1'b1, RG_NONE);
    acc(0, 0, 0, ADDR_BOOT_DATA_CFG_GUARD, 8'h00, 21'h0, 0, 8'h40);
    prog_mode = 1'b1;
    u_link.erase(1'b1, RG_NONE);
    for (int i = 0; i < PROT_REGS; i++) begin
      acc(1, 0, 0, 22'(ADDR_REGION_READ_LOCK + i), 8'h00, 21'h0, 0,
        PROT_RESET[i]);
    end
    acc(1, 1, 0, ADDR_REGION_WRITE_GUARD, 8'h0d, 21'h0, 0, 8'h00);
    u_link.erase(1'b0, RG_BLK1);
    acc(1, 0, 0, ADDR_REGION_WRITE_GUARD, 8'h00, 21'h0, 0, 8'h0f);
    $display("test erase done");
    prog_mode = 1'b0;
    debug_cfg_n = 1'b0;
    @(posedge ref_clk);
    #1;
    chk("debug enable", 8'h01, {7'h00, debug_en_r});
    acc(0, 1, 0, 22'h001e00, 8'h55, 21'h100, 1, 8'h00);
    acc(0, 1, 0, 22'h001dff, 8'h55, 21'h100, 0, 8'h00);
    $display("test debug done");
    debug_cfg_n = 1'b1;
    acc(0, 1, 1, 22'h000030, 8'h3c, 21'h0, 0, 8'h00);
    acc(0, 1, 0, ADDR_REGION_WRITE_GUARD, 8'h0b, 21'h0, 0, 8'h00);
    variant = 2'h1;
    acc(0, 1, 0, 22'h003fff, 8'h11, 21'h100, 0, 8'h00);
    variant = 2'h2;
    acc(0, 1, 0, 22'h004000, 8'h11, 21'h100, 1, 8'h00);
    acc(0, 1, 0, 22'h003fff, 8'h12, 21'h100, 0, 8'h00);
    variant = 2'h3;
    acc(0, 1, 0, 22'h008000, 8'h13, 21'h100, 1, 8'h00);
    acc(0, 1, 0, 22'h00c000, 8'h14, 21'h100, 0, 8'h00);
    acc(0, 0, 0, 22'h00ffff, 8'h00, 21'h100, 0, md(22'hffff));
    acc(0, 0, 0, 22'h010000, 8'h00, 21'h100, 0, 8'h00);
    $display("test large variants done");
    prog_mode = 1'b1;
    acc(1, 1, 0, ADDR_BOOT_DATA_LOCK, 8'h00, 21'h0, 0, 8'h00);
    u_link.erase(1'b0, RG_BOOT);
    acc(1, 0, 0, ADDR_BOOT_DATA_LOCK, 8'h00, 21'h0, 0, 8'h40);
    $display("test boot erase done");
    finish_test();
  end
endmodule
`default_nettype wire
